// ==== design/wdcp_map.svh ====
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDCP_MAP_SVH
`define WDCP_MAP_SVH
`define WDCP_OFF_CTRL      8'h00
`define WDCP_OFF_STATUS    8'h01
`define WDCP_STATUS_RST    8'h00
`define WDCP_WIN_LSB       4
`define WDCP_PER_LSB       0
`define WDCP_LOCK_BIT      7
`define WDCP_SYNC_BIT      0
// Unlock key value is arbitrary
`define WDCP_IO_UNLOCK_KEY 8'h5A
`define WDCP_UNLOCK_INSTR  3'h4
`define WDCP_SYS_CLK_HZ    50000000
`define WDCP_WDT_CLK_HZ    1024
`define WDCP_TICK_CYCLES   (`WDCP_SYS_CLK_HZ / `WDCP_WDT_CLK_HZ)
`define WDCP_SYNC_LAST     1'b1
`define WDCP_LEN_BASE      14'h0004
`define WDCP_LEN_MAX       14'h2000
`define WDCP_CODE_MAX      4'hB
`endif

// ==== design/wdcp_pkg.sv ====
// Types and helpers shared by the watchdog control and counter
`include "wdcp_map.svh"
package wdcp_pkg;

  // Counter phase in the slow domain
  typedef enum logic {
    WDCP_OPEN   = 1'b0,
    WDCP_CLOSED = 1'b1
  } wdcp_phase_e;

  // Control side state
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        lock;
    logic        sync_pend;
    logic [2:0]  key_left;
    logic        boot_seen;
    logic [7:0]  rdata;
    logic [15:0] div;
    logic        tick;
    logic        cfg_req;
  } wdcp_ctl_s;

  // Counter side state
  typedef struct packed {
    wdcp_phase_e phase;
    logic [13:0] cnt;
    logic [7:0]  cfg;
    logic [7:0]  stage;
    logic        sync_busy;
    logic        sync_cnt;
    logic        svc_pend;
    logic        svc_sync;
    logic        bite;
    logic        ack;
  } wdcp_cnt_s;

  // code to length
  // Code to length in slow ticks; reserved codes saturate to the longest
  function automatic logic [13:0] wdcp_len(input logic [3:0] code);
    if (code == 4'h0) begin
      return 14'h0000;
    end else if (code > `WDCP_CODE_MAX) begin
      return `WDCP_LEN_MAX;
    end
    return `WDCP_LEN_BASE << code;
  endfunction

endpackage

// ==== design/wdcp_if.sv ====
// Carrier between the register side and the slow-tick counter
`timescale 1ns/1ps
interface wdcp_if;
  logic       tick;
  logic       cfg_req;
  logic [7:0] cfg_data;
  logic [7:0] boot_cfg;
  logic       service;
  logic       debug;
  logic       cfg_ack;
  logic       bite;

  modport ctl (output tick, cfg_req, cfg_data, boot_cfg, service, debug,
               input cfg_ack, bite);
  modport cnt (input tick, cfg_req, cfg_data, boot_cfg, service, debug,
               output cfg_ack, bite);
endinterface

// ==== design/wdcp_counter.sv ====
// Time-out and window counter running on the slow watchdog tick
`timescale 1ns/1ps
`include "wdcp_map.svh"
module wdcp_counter (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Link to register side
  wdcp_if.cnt       ifc
);
  import wdcp_pkg::*;

  wdcp_cnt_s   st_reg;
  wdcp_cnt_s   st_next;
  logic [3:0]  per;
  logic [3:0]  win;
  logic        apply;

  assign per   = st_reg.cfg[`WDCP_PER_LSB +: 4];
  assign win   = st_reg.cfg[`WDCP_WIN_LSB +: 4];
  assign apply = ifc.tick && st_reg.sync_busy && (st_reg.sync_cnt == `WDCP_SYNC_LAST);

  assign ifc.bite    = st_reg.bite;
  assign ifc.cfg_ack = st_reg.ack;

  // Next state of the slow-domain counter
  always_comb begin
    st_next      = st_reg;
    st_next.bite = 1'b0;
    st_next.ack  = 1'b0;
    if (ifc.cfg_req) begin
      st_next.sync_busy = 1'b1;
      st_next.sync_cnt  = 1'b0;
      st_next.stage     = ifc.cfg_data;
    end
    if (ifc.service) begin
      st_next.svc_pend = 1'b1;
    end
    if (ifc.tick) begin
      st_next.svc_sync = st_reg.svc_pend;
      st_next.svc_pend = ifc.service;
      if (ifc.debug || per == 4'h0) begin
        st_next.cnt   = 14'h0000;
        st_next.phase = WDCP_OPEN;
      end else begin
        case (st_reg.phase)
          WDCP_OPEN: begin
            if (st_reg.svc_sync) begin
              st_next.cnt = 14'h0000;
              if (win != 4'h0) begin
                st_next.phase = WDCP_CLOSED;
              end
            end else if (st_reg.cnt + 14'h0001 >= wdcp_len(per)) begin
              st_next.bite = 1'b1;
              st_next.cnt  = 14'h0000;
            end else begin
              st_next.cnt = st_reg.cnt + 14'h0001;
            end
          end
          WDCP_CLOSED: begin
            if (st_reg.svc_sync) begin
              st_next.bite  = 1'b1;
              st_next.cnt   = 14'h0000;
              st_next.phase = WDCP_OPEN;
            end else if (st_reg.cnt + 14'h0001 >= wdcp_len(win)) begin
              st_next.cnt   = 14'h0000;
              st_next.phase = WDCP_OPEN;
            end else begin
              st_next.cnt = st_reg.cnt + 14'h0001;
            end
          end
          default: begin
            st_next.cnt   = 14'h0000;
            st_next.phase = WDCP_OPEN;
          end
        endcase
      end
      if (st_reg.sync_busy) begin
        st_next.sync_cnt = 1'b1;
      end
      if (apply) begin
        st_next.cfg       = st_reg.stage;
        st_next.sync_busy = 1'b0;
        st_next.ack       = 1'b1;
        st_next.cnt       = 14'h0000;
        st_next.phase     = WDCP_OPEN;
      end
    end
  end

  // Register; setting at reset comes from the fuse copy
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_reg           <= '0;
      st_reg.phase     <= WDCP_OPEN;
      st_reg.cfg       <= ifc.boot_cfg;
    end else begin
      st_reg <= st_next;
    end
  end

  property p_closed_bite;
    @(posedge i_clock) disable iff (i_rst)
      ifc.tick && st_reg.phase == WDCP_CLOSED && st_reg.svc_sync && !ifc.debug
      && per != 4'h0 |=> st_reg.bite;
  endproperty
  a_closed_bite: assert property (p_closed_bite) else $error("early service did not bite");

  property p_off_quiet;
    @(posedge i_clock) disable iff (i_rst)
      per == 4'h0 |=> !st_reg.bite;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled watchdog bit");

  property p_timeout;
    @(posedge i_clock) disable iff (i_rst)
      ifc.tick && st_reg.phase == WDCP_OPEN && !st_reg.svc_sync && !ifc.debug
      && per != 4'h0 && st_reg.cnt + 14'h0001 >= wdcp_len(per) |=> st_reg.bite;
  endproperty
  a_timeout: assert property (p_timeout) else $error("missed time-out reset");

endmodule

// ==== design/wdcp_top.sv ====
// Register, unlock and lock logic of the windowed watchdog
//
// Operation
// - Unlock key opens a four-instruction interval for one protected write.
// - Protected writes without a valid unlock leave contents unchanged.
// - Control at offset 0x00: closed window 7:4, time-out 3:0, protected.
// - Non-zero closed-window code enables window operation and its length.
// - Non-zero time-out code enables watchdog; zero keeps it off.
// - In window operation time-out code sets the open interval length.
// - Codes 0x1..0xB give 8 to 8K slow cycles; others reserved.
// - Lock set makes the whole control register read-only.
// - Lock at status bit 7 set by software, cleared only in debug.
// - Non-zero time-out after boot sets the lock automatically.
// - Writing the lock needs the unlock sequence.
// - Sync-pending at status bit 0 high while control crosses domains.
// - Sync-pending flag is not under the unlock mechanism.
// - Status at offset 0x01, resets to 0x00.
// - Control register loads from the boot fuse at reset.
// - Missing service within time-out gives a system reset; service restarts.
// - Service during the closed interval gives a system reset.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "wdcp_map.svh"
module wdcp_top #(
  parameter int TICK_DIV = `WDCP_TICK_CYCLES
) (
  // Clock and reset
  input  wire  logic       i_clock,
  input  wire  logic       i_rst,
  // Register port
  input  wire  logic [7:0] i_addr,
  input  wire  logic [7:0] i_wdata,
  input  wire  logic       i_wr,
  input  wire  logic       i_rd,
  output logic       [7:0] o_rdata,
  // Processor side
  input  wire  logic       i_key_wr,
  input  wire  logic [7:0] i_key_data,
  input  wire  logic       i_instr,
  input  wire  logic       i_service,
  input  wire  logic       i_debug,
  input  wire  logic       i_boot_done,
  input  wire  logic [7:0] i_fuse_cfg,
  // Status and system reset
  output logic             o_sync_pending,
  output logic             o_locked,
  output logic             o_enabled,
  output logic             o_window,
  output logic             o_sys_reset
);
  import wdcp_pkg::*;

  //--------------------------------------------------------------
  // State and link
  //--------------------------------------------------------------

  wdcp_ctl_s st_reg;
  wdcp_ctl_s st_next;
  wdcp_if    link ();
  logic      unlocked;
  logic      key_ok;
  logic      wr_ctrl;
  logic      wr_stat;
  logic      ctrl_take;

  // Decoded strobes, shared by logic and checks
  assign unlocked  = st_reg.key_left != 3'h0;
  assign key_ok    = i_key_wr && (i_key_data == `WDCP_IO_UNLOCK_KEY);
  assign wr_ctrl   = i_wr && (i_addr == `WDCP_OFF_CTRL);
  assign wr_stat   = i_wr && (i_addr == `WDCP_OFF_STATUS);
  assign ctrl_take = wr_ctrl && unlocked && !st_reg.lock && !st_reg.sync_pend;

  // Link drive; fuse copy lets the counter start with the same setting
  assign link.tick     = st_reg.tick;
  assign link.cfg_req  = st_reg.cfg_req;
  assign link.cfg_data = st_reg.ctrl;
  assign link.boot_cfg = i_fuse_cfg;
  assign link.service  = i_service;
  assign link.debug    = i_debug;

  //--------------------------------------------------------------
  // Slow-domain counter
  //--------------------------------------------------------------

  wdcp_counter u_counter (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .ifc     (link.cnt)
  );

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------

  // One process for divider, unlock, registers and read data
  always_comb begin
    st_next         = st_reg;
    st_next.tick    = 1'b0;
    st_next.cfg_req = 1'b0;
    st_next.rdata   = 8'h00;

    if (st_reg.div == 16'(TICK_DIV - 1)) begin
      st_next.div  = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.div = st_reg.div + 16'h0001;
    end

    if (key_ok) begin
      st_next.key_left = `WDCP_UNLOCK_INSTR;
    end else if (i_instr && unlocked) begin
      st_next.key_left = st_reg.key_left - 3'h1;
    end

    if (ctrl_take) begin
      st_next.ctrl      = i_wdata;
      st_next.sync_pend = 1'b1;
      st_next.cfg_req   = 1'b1;
      st_next.key_left  = 3'h0;
    end

    if (link.cfg_ack) begin
      st_next.sync_pend = 1'b0;
    end

    if (wr_stat && unlocked) begin
      st_next.key_left = 3'h0;
      if (i_wdata[`WDCP_LOCK_BIT]) begin
        st_next.lock = 1'b1;
      end else if (i_debug) begin
        st_next.lock = 1'b0;
      end
    end

    if (i_boot_done && !st_reg.boot_seen) begin
      st_next.boot_seen = 1'b1;
      if (st_reg.ctrl[`WDCP_PER_LSB +: 4] != 4'h0) begin
        st_next.lock = 1'b1;
      end
    end

    if (i_rd) begin
      case (i_addr)
        `WDCP_OFF_CTRL: begin
          st_next.rdata = st_reg.ctrl;
        end
        `WDCP_OFF_STATUS: begin
          st_next.rdata = `WDCP_STATUS_RST;
          st_next.rdata[`WDCP_LOCK_BIT] = st_reg.lock;
          st_next.rdata[`WDCP_SYNC_BIT] = st_reg.sync_pend;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // State register
  //--------------------------------------------------------------

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_reg      <= '0;
      st_reg.ctrl <= i_fuse_cfg;
    end else begin
      st_reg <= st_next;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------

  assign o_rdata        = st_reg.rdata;
  assign o_sync_pending = st_reg.sync_pend;
  assign o_locked       = st_reg.lock;
  assign o_enabled      = st_reg.ctrl[`WDCP_PER_LSB +: 4] != 4'h0;
  assign o_window       = st_reg.ctrl[`WDCP_WIN_LSB +: 4] != 4'h0;
  assign o_sys_reset    = link.bite;

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------

  property p_no_key;
    @(posedge i_clock) disable iff (i_rst)
      wr_ctrl && !unlocked |=> $stable(st_reg.ctrl);
  endproperty
  a_no_key: assert property (p_no_key) else $error("control changed without unlock");

  property p_locked;
    @(posedge i_clock) disable iff (i_rst)
      wr_ctrl && st_reg.lock |=> st_reg.ctrl == $past(st_reg.ctrl);
  endproperty
  a_locked: assert property (p_locked) else $error("locked control changed");

  property p_unlock_take;
    @(posedge i_clock) disable iff (i_rst)
      key_ok ##1 (wr_ctrl && !st_reg.lock && !st_reg.sync_pend)
      |=> st_reg.ctrl == $past(i_wdata) && st_reg.sync_pend;
  endproperty
  a_unlock_take: assert property (p_unlock_take) else $error("unlocked write not taken");

  property p_lock_fall;
    @(posedge i_clock) disable iff (i_rst)
      $fell(st_reg.lock) |-> $past(i_debug) && $past(wr_stat);
  endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("lock cleared outside debug");

  property p_boot_lock;
    @(posedge i_clock) disable iff (i_rst)
      i_boot_done && !st_reg.boot_seen && o_enabled |=> st_reg.lock;
  endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("boot did not lock");

  property p_status_read;
    @(posedge i_clock) disable iff (i_rst)
      i_rd && i_addr == `WDCP_OFF_STATUS
      |=> o_rdata == {$past(st_reg.lock), 6'h00, $past(st_reg.sync_pend)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  //--------------------------------------------------------------
  // Handshake, unlock, lock and read checks
  //--------------------------------------------------------------

  property p_sync_rise;
    @(posedge i_clock) disable iff (i_rst)
      ctrl_take |=> st_reg.sync_pend;
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync flag did not rise");

  property p_sync_clear;
    @(posedge i_clock) disable iff (i_rst)
      link.cfg_ack |=> !st_reg.sync_pend;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync flag did not clear");

  property p_sync_hold;
    @(posedge i_clock) disable iff (i_rst)
      st_reg.sync_pend && !link.cfg_ack |=> st_reg.sync_pend;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync flag fell early");

  property p_busy_drop;
    @(posedge i_clock) disable iff (i_rst)
      wr_ctrl && st_reg.sync_pend |=> $stable(st_reg.ctrl);
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("control changed while crossing");

  property p_lock_hold;
    @(posedge i_clock) disable iff (i_rst)
      st_reg.lock && !i_debug |=> st_reg.lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock fell outside debug");

  property p_lock_nokey;
    @(posedge i_clock) disable iff (i_rst)
      wr_stat && !unlocked && !(i_boot_done && !st_reg.boot_seen) |=> $stable(st_reg.lock);
  endproperty
  a_lock_nokey: assert property (p_lock_nokey) else $error("lock changed without unlock");

  property p_key_load;
    @(posedge i_clock) disable iff (i_rst)
      key_ok && !ctrl_take && !(wr_stat && unlocked)
      |=> st_reg.key_left == `WDCP_UNLOCK_INSTR;
  endproperty
  a_key_load: assert property (p_key_load) else $error("unlock interval not loaded");

  property p_key_close;
    @(posedge i_clock) disable iff (i_rst)
      ctrl_take |=> st_reg.key_left == 3'h0;
  endproperty
  a_key_close: assert property (p_key_close) else $error("unlock interval left open");

  property p_ctrl_read;
    @(posedge i_clock) disable iff (i_rst)
      i_rd && i_addr == `WDCP_OFF_CTRL |=> o_rdata == $past(st_reg.ctrl);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_rdata_idle;
    @(posedge i_clock) disable iff (i_rst)
      !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the watchdog register and protection block
`timescale 1ns/1ps
`include "wdcp_map.svh"
module tb_top;
  import wdcp_pkg::*;
  // Short slow tick keeps time-outs to a few hundred clocks
  localparam int TD = 6;
  logic       i_clock, i_rst, i_wr, i_rd, i_key_wr, i_instr, i_service;
  logic       i_debug, i_boot_done;
  logic [7:0] i_addr, i_wdata, i_key_data, i_fuse_cfg, o_rdata;
  logic       o_sync_pending, o_locked, o_enabled, o_window, o_sys_reset;
  int         bad_count = 0;
  int         checks = 0;
  int         cycles = 0;
  int         sr_count = 0;
  int         seed, k, s0, ctrl_m, lock_m, sync_m;

  wdcp_top #(.TICK_DIV(TD)) DUT (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_key_wr(i_key_wr),
    .i_key_data(i_key_data), .i_instr(i_instr), .i_service(i_service),
    .i_debug(i_debug), .i_boot_done(i_boot_done), .i_fuse_cfg(i_fuse_cfg),
    .o_sync_pending(o_sync_pending), .o_locked(o_locked), .o_enabled(o_enabled),
    .o_window(o_window), .o_sys_reset(o_sys_reset)
  );

  // 50 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // Count reset pulses; cycle ceiling cuts a hang short
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (o_sys_reset === 1'b1) begin
      sr_count <= sr_count + 1;
    end
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Settle past the edge so design updates have landed
  task automatic cyc;
    @(posedge i_clock);
    #1;
  endtask

  // Trailing idle cycle keeps two reads from touching the strobe at once
  task automatic rd(input logic [7:0] a, input int exp);
    i_rd   <= 1'b1;
    i_addr <= a;
    cyc();
    i_rd <= 1'b0;
    chk("rdata", o_rdata, 8'(exp));
    cyc();
  endtask

  // Both registers and the decoded flags against the model
  task automatic regs;
    rd(`WDCP_OFF_CTRL, ctrl_m);
    rd(`WDCP_OFF_STATUS, lock_m * 128 + sync_m);
    chk("locked", o_locked, 8'(lock_m));
    chk("enabled", o_enabled, 8'((ctrl_m & 15) != 0));
    chk("window", o_window, 8'((ctrl_m >> 4) != 0));
  endtask

  // Key 0 none, 1 correct, 2 wrong; n instructions between key and write
  task automatic pwr(input logic [7:0] a, input logic [7:0] d, input int n, input int key);
    bit acc;
    acc = key == 1 && n < 4;
    if (key != 0) begin
      i_key_wr   <= 1'b1;
      i_key_data <= (key == 1) ? `WDCP_IO_UNLOCK_KEY : ~`WDCP_IO_UNLOCK_KEY;
      cyc();
      i_key_wr <= 1'b0;
    end else begin
      cyc();
    end
    repeat (n) begin
      i_instr <= 1'b1;
      cyc();
    end
    i_instr <= 1'b0;
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    cyc();
    i_wr <= 1'b0;
    if (a == `WDCP_OFF_CTRL && acc && lock_m == 0 && sync_m == 0) begin
      ctrl_m = d;
      sync_m = 1;
      chk("sync_rise", o_sync_pending, 8'h01);
    end
    if (a == `WDCP_OFF_STATUS && acc && (d[7] || i_debug)) begin
      lock_m = d[7];
    end
  endtask

  // Crossing ends within two slow ticks plus the hand-off
  task automatic wait_sync;
    for (k = 0; k < 2 * TD + 4 && o_sync_pending !== 1'b0; k++) begin
      cyc();
    end
    chk("sync_clear", o_sync_pending, 8'h00);
    sync_m = 0;
  endtask

  task automatic do_reset(input logic [7:0] f);
    i_rst       <= 1'b1;
    i_fuse_cfg  <= f;
    i_boot_done <= 1'b0;
    cyc();
    cyc();
    i_rst  <= 1'b0;
    ctrl_m = f;
    lock_m = 0;
    sync_m = 0;
  endtask

  task automatic service;
    i_service <= 1'b1;
    cyc();
    i_service <= 1'b0;
    cyc();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_rst, i_wr, i_rd, i_key_wr, i_instr, i_service, i_debug, i_boot_done} = 8'h80;
    i_addr     = 8'h00;
    i_wdata    = 8'h00;
    i_key_data = 8'h00;
    i_fuse_cfg = 8'h00;
    seed       = 6;
    do_reset(8'h00);
    // zero fuse: boot leaves lock clear
    i_boot_done <= 1'b1;
    cyc();
    regs();
    rd(8'h02, 0);
    // unkeyed, wrong key and unmapped writes leave contents
    pwr(`WDCP_OFF_CTRL, 8'h21, 0, 0);
    pwr(`WDCP_OFF_CTRL, 8'h44, 0, 2);
    pwr(`WDCP_OFF_STATUS, 8'h80, 0, 0);
    pwr(8'h05, 8'hFF, 0, 1);
    regs();
    $display("test reset_and_guard done");
    // every code, random gap, second write during crossing
    for (int i = 0; i < 16; i++) begin
      pwr(`WDCP_OFF_CTRL, 8'(i * 16 + 15 - i), {$random(seed)} % 6, 1);
      pwr(`WDCP_OFF_CTRL, 8'(~ctrl_m), 0, 1);
      wait_sync();
      regs();
    end
    $display("test unlock_and_sync done");
    // lock set, control frozen, clear only in debug
    pwr(`WDCP_OFF_STATUS, 8'h81, 0, 1);
    pwr(`WDCP_OFF_CTRL, 8'h00, 0, 1);
    pwr(`WDCP_OFF_STATUS, 8'h00, 0, 1);
    regs();
    i_debug <= 1'b1;
    pwr(`WDCP_OFF_STATUS, 8'h00, 0, 1);
    regs();
    $display("test lock done");
    // fused period locks at boot and bites after 32 ticks
    i_debug <= 1'b0;
    do_reset(8'h03);
    i_boot_done <= 1'b1;
    s0 = sr_count;
    for (k = 0; k < 34 * TD && sr_count == s0; k++) begin
      cyc();
    end
    chk("locked", o_locked, 8'h01);
    chk("bite_time", 8'(k >= 30 * TD && sr_count == s0 + 1), 8'h01);
    lock_m = 1;
    pwr(`WDCP_OFF_CTRL, 8'h00, 0, 1);
    regs();
    // Service every 16 ticks holds off a 32-tick time-out
    s0 = sr_count;
    repeat (3) begin
      repeat (16 * TD) cyc();
      service();
    end
    chk("no_bite", 8'(sr_count - s0), 8'h00);
    $display("test timeout done");
    // window of 8 ticks, early service in closed phase bites
    i_debug <= 1'b1;
    pwr(`WDCP_OFF_STATUS, 8'h00, 0, 1);
    pwr(`WDCP_OFF_CTRL, 8'h11, 0, 1);
    wait_sync();
    regs();
    i_debug <= 1'b0;
    s0 = sr_count;
    service();
    repeat (4 * TD) cyc();
    chk("open_service", 8'(sr_count - s0), 8'h00);
    service();
    repeat (8 * TD) cyc();
    chk("closed_bite", 8'(sr_count - s0), 8'h01);
    $display("test window done");
    stop_test();
  end
endmodule
